// >>> hdl/conv_ctrl.sv
// Converter trigger, clock divider, busy flag, interrupt and boundary compare logic.
`timescale 1ns/100ps
`default_nettype none
module conv_ctrl
  import conv_ctrl_pkg::*;
#(
  parameter int DATA_W = 10
) (
  // Clock and reset.
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  // Avalon-MM slave.
  input wire logic [5:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  // PWM module strobes.
  input wire pwm_strobe_t PWM_STROBE_IN,
  // Converter core.
  input wire logic CORE_DONE_IN,
  input wire logic [DATA_W-1:0] CORE_RESULT_IN,
  output logic CORE_RESET_OUT,
  output logic CORE_START_OUT,
  output logic CORE_CLK_EN_OUT,
  output logic CORE_POWER_ON_OUT,
  output logic [2:0] INPUT_CHANNEL_SEL_OUT,
  // Interrupt.
  output logic IRQ_OUT
);

  // ==========================================================================
  // Registers.
  logic [7:0] control_0_q;
  logic [7:0] control_1_q;
  logic [1:0] duty_channel_sel_q;
  logic [7:0] trigger_delay_count_q;
  logic [DATA_W-1:0] low_bound_q;
  logic [DATA_W-1:0] high_bound_q;
  logic [DATA_W-1:0] result_q;
  logic conv_done_flag_q;
  logic busy_q;
  logic bound_flag_q;
  logic conv_done_irq_enable_q;
  logic bound_irq_enable_q;
  logic global_irq_enable_q;
  logic ack_q;
  logic [7:0] delay_cnt_q;
  logic [5:0] div_cnt_q;
  conv_state_t state_q;
  logic start_prev_q;
  logic done_pulse;
  logic bound_hit;
  logic pwm_trig;
  logic sel_trig;
  logic wr;
  logic rd;
  logic [3:0] idx;
  logic [7:0] wbyte;
  logic [5:0] div_mask;

  // Word index from a byte address; one wait state gives every access one cycle to settle.
  assign idx = AVS_ADDRESS_IN[5:2];
  assign wbyte = AVS_WRITEDATA_IN[7:0];
  assign wr = AVS_WRITE_IN && ack_q && AVS_BYTEENABLE_IN[0];
  assign rd = AVS_READ_IN && !ack_q;
  assign AVS_WAITREQUEST_OUT = (AVS_READ_IN || AVS_WRITE_IN) && !ack_q;

  // Acknowledge toggles so each request completes on its second edge.
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (AVS_READ_IN || AVS_WRITE_IN) && !ack_q;
    end
  end

  // Control register writes; busy bit is owned by the sequencer below.
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      control_0_q <= CR0_RESET;
      control_1_q <= ZERO_RESET;
      duty_channel_sel_q <= 2'h0;
      trigger_delay_count_q <= ZERO_RESET;
      low_bound_q <= '0;
      high_bound_q <= '0;
      conv_done_irq_enable_q <= 1'b0;
      bound_irq_enable_q <= 1'b0;
      global_irq_enable_q <= 1'b0;
    end else if (wr) begin
      case (idx)
        IDX_CONTROL_0: begin
          control_0_q <= {wbyte[7], control_0_q[6], wbyte[5], 2'b00, wbyte[2:0]};
        end
        IDX_CONTROL_1: control_1_q <= wbyte;
        IDX_CONTROL_2: duty_channel_sel_q <= wbyte[1:0];
        IDX_DELAY: trigger_delay_count_q <= wbyte;
        IDX_LOW_BOUND_LOW_BYTE: low_bound_q[7:0] <= wbyte;
        IDX_LOW_BOUND_HIGH_BITS: low_bound_q[9:8] <= wbyte[1:0];
        IDX_HIGH_BOUND_LOW_BYTE: high_bound_q[7:0] <= wbyte;
        IDX_HIGH_BOUND_HIGH_BITS: high_bound_q[9:8] <= wbyte[1:0];
        IDX_IRQ: begin
          conv_done_irq_enable_q <= wbyte[IRQ_DONE_EN];
          bound_irq_enable_q <= wbyte[IRQ_BOUND_EN];
          global_irq_enable_q <= wbyte[IRQ_GLOBAL_EN];
        end
        default: ;
      endcase
    end
  end

  // Read mux; unmapped words and unused bits read zero.
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      AVS_READDATA_OUT <= '0;
    end else if (rd) begin
      case (idx)
        IDX_CONTROL_0: AVS_READDATA_OUT <= {24'h0, control_0_q[7], busy_q, control_0_q[5:0]};
        IDX_CONTROL_1: AVS_READDATA_OUT <= {24'h0, control_1_q};
        IDX_CONTROL_2: AVS_READDATA_OUT <= {30'h0, duty_channel_sel_q};
        IDX_DELAY: AVS_READDATA_OUT <= {24'h0, trigger_delay_count_q};
        IDX_LOW_BOUND_LOW_BYTE: AVS_READDATA_OUT <= {24'h0, low_bound_q[7:0]};
        IDX_LOW_BOUND_HIGH_BITS: AVS_READDATA_OUT <= {30'h0, low_bound_q[9:8]};
        IDX_HIGH_BOUND_LOW_BYTE: AVS_READDATA_OUT <= {24'h0, high_bound_q[7:0]};
        IDX_HIGH_BOUND_HIGH_BITS: AVS_READDATA_OUT <= {30'h0, high_bound_q[9:8]};
        IDX_RESULT_LOW: AVS_READDATA_OUT <= {24'h0, result_q[7:0]};
        IDX_RESULT_HIGH: AVS_READDATA_OUT <= {30'h0, result_q[9:8]};
        IDX_IRQ: begin
          AVS_READDATA_OUT <= {27'h0, global_irq_enable_q, bound_irq_enable_q,
                               conv_done_irq_enable_q, bound_flag_q, conv_done_flag_q};
        end
        default: AVS_READDATA_OUT <= '0;
      endcase
    end
  end

  // Converter clock enable: one pulse every 2^sel system clocks, code 111 stops it.
  assign div_mask = 6'((7'h1 << control_1_q[2:0]) - 7'h1);
  assign CORE_CLK_EN_OUT = (control_1_q[2:0] <= DIV_SEL_MAX) &&
                           ((div_cnt_q & div_mask) == div_mask);
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + 6'h1;
    end
  end

  // Trigger selection between period strobe and the chosen duty channel.
  always_comb begin
    case (duty_channel_sel_q)
      2'h0: sel_trig = PWM_STROBE_IN.duty_irq[0];
      2'h1: sel_trig = PWM_STROBE_IN.duty_irq[1];
      default: sel_trig = PWM_STROBE_IN.duty_irq[2];
    endcase
  end
  assign pwm_trig = control_1_q[CR1_METHOD] &&
                    (control_1_q[CR1_PWM_SRC] ? sel_trig : PWM_STROBE_IN.period_irq);

  // Conversion sequencer. With the method bit clear, a start bit held high resets the core and holds busy high;
  // the falling edge starts it. PWM triggers arriving mid-conversion are dropped.
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_q <= ST_IDLE;
      start_prev_q <= 1'b0;
      delay_cnt_q <= '0;
      CORE_START_OUT <= 1'b0;
      CORE_RESET_OUT <= 1'b0;
    end else begin
      start_prev_q <= control_0_q[CR0_START];
      CORE_START_OUT <= 1'b0;
      CORE_RESET_OUT <= 1'b0;
      if (!control_1_q[CR1_METHOD] && control_0_q[CR0_START]) begin
        state_q <= ST_HOLD;
        CORE_RESET_OUT <= 1'b1;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (pwm_trig && control_1_q[CR1_DELAY_EN] && trigger_delay_count_q != 8'h0) begin
              state_q <= ST_DELAY;
              delay_cnt_q <= trigger_delay_count_q - 8'h1;
            end else if (pwm_trig) begin
              state_q <= ST_CONVERT;
              CORE_START_OUT <= 1'b1;
            end
          end
          ST_DELAY: begin
            if (delay_cnt_q == 8'h0) begin
              state_q <= ST_CONVERT;
              CORE_START_OUT <= 1'b1;
            end else begin
              delay_cnt_q <= delay_cnt_q - 8'h1;
            end
          end
          ST_HOLD: begin
            if (start_prev_q) begin
              state_q <= ST_CONVERT;
              CORE_START_OUT <= 1'b1;
            end
          end
          ST_CONVERT: begin
            if (CORE_DONE_IN) begin
              state_q <= ST_IDLE;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  assign done_pulse = (state_q == ST_CONVERT) && CORE_DONE_IN &&
                      !(control_0_q[CR0_START] && !control_1_q[CR1_METHOD]);

  // Busy flag; the control_0 readback shows it in place of the stored bit 6.
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      busy_q <= 1'b1;
    end else if (done_pulse) begin
      busy_q <= 1'b0;
    end else if (state_q != ST_IDLE || CORE_RESET_OUT) begin
      busy_q <= 1'b1;
    end
  end

  // Boundary compare on the incoming result, per selected mode.
  always_comb begin
    case ({control_1_q[CR1_UPPER_CMP], control_1_q[CR1_LOWER_CMP]})
      2'b00: bound_hit = (CORE_RESULT_IN > low_bound_q) && (CORE_RESULT_IN < high_bound_q);
      2'b01: bound_hit = CORE_RESULT_IN <= low_bound_q;
      2'b10: bound_hit = CORE_RESULT_IN >= high_bound_q;
      default: bound_hit = (CORE_RESULT_IN <= low_bound_q) || (CORE_RESULT_IN >= high_bound_q);
    endcase
  end

  // Result latch and sticky flags; a new event wins over a same-cycle clear.
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      result_q <= '0;
      conv_done_flag_q <= 1'b0;
      bound_flag_q <= 1'b0;
    end else begin
      if (done_pulse) begin
        result_q <= CORE_RESULT_IN;
        conv_done_flag_q <= 1'b1;
      end else if (wr && idx == IDX_IRQ && wbyte[IRQ_DONE_FLAG]) begin
        conv_done_flag_q <= 1'b0;
      end
      if (done_pulse && bound_hit) begin
        bound_flag_q <= 1'b1;
      end else if (wr && idx == IDX_IRQ && wbyte[IRQ_BOUND_FLAG]) begin
        bound_flag_q <= 1'b0;
      end
    end
  end

  assign IRQ_OUT = global_irq_enable_q && ((conv_done_flag_q && conv_done_irq_enable_q) ||
                   (bound_flag_q && bound_irq_enable_q));
  assign CORE_POWER_ON_OUT = !control_0_q[CR0_POWER_OFF];
  assign INPUT_CHANNEL_SEL_OUT = control_0_q[2:0];

  // ==========================================================================
  // Assertions.
  property p_done_clears_busy;
    @(posedge CLK_IN) disable iff (!RESET_N_IN) done_pulse |=> !busy_q;
  endproperty
  a_done_clears_busy: assert property (p_done_clears_busy) else $error("busy not cleared");
  property p_done_sets_flag;
    @(posedge CLK_IN) disable iff (!RESET_N_IN) done_pulse |=> conv_done_flag_q;
  endproperty
  a_done_sets_flag: assert property (p_done_sets_flag) else $error("done flag not set");
  property p_start_rise_resets;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (!control_1_q[CR1_METHOD] && control_0_q[CR0_START]) |=> CORE_RESET_OUT && state_q == ST_HOLD;
  endproperty
  a_start_rise_resets: assert property (p_start_rise_resets) else $error("no reset");
  sequence s_soft_release;
    state_q == ST_HOLD && !control_0_q[CR0_START] && start_prev_q && !control_1_q[CR1_METHOD];
  endsequence
  property p_soft_start;
    @(posedge CLK_IN) disable iff (!RESET_N_IN) s_soft_release |=> CORE_START_OUT;
  endproperty
  a_soft_start: assert property (p_soft_start) else $error("no soft start");
  // Two quiet cycles of delay, then the start pulse.
  sequence s_two_quiet_then_start;
    !CORE_START_OUT ##1 !CORE_START_OUT ##1 CORE_START_OUT;
  endsequence
  property p_delay_wait;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (state_q == ST_IDLE && pwm_trig && control_1_q[CR1_DELAY_EN] &&
       trigger_delay_count_q == 8'h2 && !control_0_q[CR0_START]) |=> s_two_quiet_then_start;
  endproperty
  a_delay_wait: assert property (p_delay_wait) else $error("delay wrong");
  property p_no_delay;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (state_q == ST_IDLE && pwm_trig && !control_1_q[CR1_DELAY_EN] && !control_0_q[CR0_START])
      |=> CORE_START_OUT;
  endproperty
  a_no_delay: assert property (p_no_delay) else $error("pwm start missing");
  property p_bound_flag;
    @(posedge CLK_IN) disable iff (!RESET_N_IN) (done_pulse && bound_hit) |=> bound_flag_q;
  endproperty
  a_bound_flag: assert property (p_bound_flag) else $error("bound flag missing");
  property p_irq_gate;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (done_pulse && conv_done_irq_enable_q && global_irq_enable_q && !(wr && idx == IDX_IRQ))
      |=> IRQ_OUT;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq missing");
  property p_power;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (wr && idx == IDX_CONTROL_0) |=> CORE_POWER_ON_OUT == !$past(wbyte[CR0_POWER_OFF]);
  endproperty
  a_power: assert property (p_power) else $error("power wrong");
endmodule
`default_nettype wire

// >>> hdl/conv_ctrl_pkg.sv
// Package of register offsets, field positions, reset values and types for the converter control.
package conv_ctrl_pkg;
  // ==========================================================================
  // Register word indices (byte address is four times the index).
  localparam logic [3:0] IDX_CONTROL_0 = 4'h0;
  localparam logic [3:0] IDX_CONTROL_1 = 4'h1;
  localparam logic [3:0] IDX_CONTROL_2 = 4'h2;
  localparam logic [3:0] IDX_DELAY = 4'h3;
  localparam logic [3:0] IDX_LOW_BOUND_LOW_BYTE = 4'h4;
  localparam logic [3:0] IDX_LOW_BOUND_HIGH_BITS = 4'h5;
  localparam logic [3:0] IDX_HIGH_BOUND_LOW_BYTE = 4'h6;
  localparam logic [3:0] IDX_HIGH_BOUND_HIGH_BITS = 4'h7;
  localparam logic [3:0] IDX_RESULT_LOW = 4'h8;
  localparam logic [3:0] IDX_RESULT_HIGH = 4'h9;
  localparam logic [3:0] IDX_IRQ = 4'ha;
  // ==========================================================================
  // Field positions.
  localparam int CR0_START = 7;
  localparam int CR0_BUSY = 6;
  localparam int CR0_POWER_OFF = 5;
  localparam int CR1_METHOD = 7;
  localparam int CR1_DELAY_EN = 6;
  localparam int CR1_PWM_SRC = 5;
  localparam int CR1_UPPER_CMP = 4;
  localparam int CR1_LOWER_CMP = 3;
  localparam int IRQ_DONE_FLAG = 0;
  localparam int IRQ_BOUND_FLAG = 1;
  localparam int IRQ_DONE_EN = 2;
  localparam int IRQ_BOUND_EN = 3;
  localparam int IRQ_GLOBAL_EN = 4;
  // ==========================================================================
  // Reset values.
  localparam logic [7:0] CR0_RESET = 8'h60;
  localparam logic [7:0] ZERO_RESET = 8'h00;
  // ==========================================================================
  // Timing: converter core takes sixteen converter clock periods.
  localparam int CONV_CLOCKS = 16;
  localparam logic [2:0] DIV_SEL_MAX = 3'h6;
  // ==========================================================================
  // Types.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_CONVERT = 2'b11,
    ST_HOLD = 2'b10
  } conv_state_t;
  typedef struct packed {
    logic period_irq;
    logic [2:0] duty_irq;
  } pwm_strobe_t;
endpackage

// >>> verif/conv_partner.sv
// Far-side model: motor timer strobe source and a behavioural converter core.
`timescale 1ns/100ps
`default_nettype none
module conv_partner
  import conv_ctrl_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Bench commands.
  input wire pwm_strobe_t fire_in,
  input wire logic [9:0] result_in,
  // Controller side.
  input wire logic core_start_in,
  input wire logic core_reset_in,
  input wire logic core_clk_en_in,
  output pwm_strobe_t strobe_out,
  output logic core_done_out,
  output logic [9:0] core_result_out
);
  logic busy_q;
  int ticks_q;
  // ==========================================================================
  // Timer strobes
  // Each strobe lasts one cycle, as the motor timer issues them.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strobe_out <= '0;
    end else begin
      strobe_out <= fire_in;
    end
  end
  // ==========================================================================
  // Converter core
  // The result toggles outside the done cycle so a late sample cannot pass.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy_q <= 1'b0;
      ticks_q <= 0;
      core_done_out <= 1'b0;
      core_result_out <= '0;
    end else begin
      core_done_out <= 1'b0;
      core_result_out <= ~core_result_out;
      if (core_reset_in) begin
        busy_q <= 1'b0;
      end else if (core_start_in) begin
        busy_q <= 1'b1;
        ticks_q <= 0;
      end else if (busy_q && core_clk_en_in) begin
        ticks_q <= ticks_q + 1;
        if (ticks_q == CONV_CLOCKS - 1) begin
          busy_q <= 1'b0;
          core_done_out <= 1'b1;
          core_result_out <= result_in;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/conv_ctrl_bench.sv
// Self-checking bench for the converter control block.
`timescale 1ns/100ps
`default_nettype none
module conv_ctrl_bench;
  import conv_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdata;
  logic waitreq;
  pwm_strobe_t fire = '0;
  pwm_strobe_t strobe;
  logic [9:0] res = '0;
  logic done, core_rst, start, clk_en, pwr, irq;
  logic [9:0] core_res;
  logic [2:0] chan;
  logic [31:0] got;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int rs[5] = '{50, 100, 150, 200, 250};
  conv_ctrl conv_ctrl_inst (.CLK_IN(clk), .RESET_N_IN(rst_n), .AVS_ADDRESS_IN(addr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq), .PWM_STROBE_IN(strobe),
    .CORE_DONE_IN(done), .CORE_RESULT_IN(core_res), .CORE_RESET_OUT(core_rst),
    .CORE_START_OUT(start), .CORE_CLK_EN_OUT(clk_en), .CORE_POWER_ON_OUT(pwr),
    .INPUT_CHANNEL_SEL_OUT(chan), .IRQ_OUT(irq));
  conv_partner conv_partner_inst (.clk_in(clk), .reset_n_in(rst_n), .fire_in(fire),
    .result_in(res), .core_start_in(start), .core_reset_in(core_rst),
    .core_clk_en_in(clk_en), .strobe_out(strobe), .core_done_out(done),
    .core_result_out(core_res));
  // Free-running 20 MHz clock and a hang guard well above the expected run.
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  // ==========================================================================
  // Helpers
  task automatic end_of_test();
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One bus cycle; the request stands until waitrequest is sampled low.
  task automatic av(input logic [3:0] idx, input logic [7:0] d, input logic w);
    @(posedge clk);
    addr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    got = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rd_check(input logic [3:0] idx, input logic [7:0] exp);
    av(idx, 8'h00, 1'b0);
    check(got, {24'h000000, exp});
  endtask
  task automatic wait_on(input int which, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((which == 0 ? done : which == 1 ? start : clk_en) !== 1'b1 && n < 300);
  endtask
  // Start bit high then low; busy must read high while the bit is held.
  task automatic soft_conv(input logic [9:0] r);
    int n;
    res <= r;
    av(IDX_CONTROL_0, 8'h80, 1'b1);
    repeat (2) @(posedge clk);
    check(core_rst, 1'b1);
    rd_check(IDX_CONTROL_0, 8'hc0);
    av(IDX_CONTROL_0, 8'h00, 1'b1);
    wait_on(0, n);
    repeat (2) @(posedge clk);
  endtask
  // Latency from the sampled strobe to the start pulse; 300 means no start.
  task automatic pwm_lat(input pwm_strobe_t s, input int exp);
    int n;
    @(posedge clk);
    fire <= s;
    @(posedge clk);
    fire <= '0;
    wait_on(1, n);
    check(n, exp);
    if (n < 300) begin
      wait_on(0, n);
    end
  endtask
  function automatic logic bnd(input int m, input int r);
    case (m)
      0: return r > 100 && r < 200;
      1: return r <= 100;
      2: return r >= 200;
      default: return r <= 100 || r >= 200;
    endcase
  endfunction
  // ==========================================================================
  // Main sequence
  initial begin
    int n;
    int ch;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_check(IDX_CONTROL_0, CR0_RESET);
    check(pwr, 1'b0);
    rd_check(IDX_CONTROL_1, 8'h00);
    rd_check(IDX_DELAY, 8'h00);
    rd_check(IDX_HIGH_BOUND_LOW_BYTE, 8'h00);
    rd_check(IDX_HIGH_BOUND_HIGH_BITS, 8'h00);
    av(IDX_HIGH_BOUND_HIGH_BITS, 8'hff, 1'b1);
    rd_check(IDX_HIGH_BOUND_HIGH_BITS, 8'h03);
    av(IDX_HIGH_BOUND_LOW_BYTE, 8'h5a, 1'b1);
    rd_check(IDX_HIGH_BOUND_LOW_BYTE, 8'h5a);
    av(IDX_DELAY, 8'hff, 1'b1);
    rd_check(IDX_DELAY, 8'hff);
    be <= 4'he;
    av(IDX_DELAY, 8'h12, 1'b1);
    be <= 4'hf;
    rd_check(IDX_DELAY, 8'hff);
    rd_check(4'hb, 8'h00);
    av(IDX_CONTROL_0, 8'h06, 1'b1);
    @(posedge clk);
    check(pwr, 1'b1);
    check(chan, 3'h6);
    for (int s = 0; s < 7; s++) begin
      av(IDX_CONTROL_1, 8'(s), 1'b1);
      wait_on(2, n);
      wait_on(2, n);
      check(n, 1 << s);
    end
    av(IDX_CONTROL_1, 8'h07, 1'b1);
    wait_on(2, n);
    check(n, 300);
    // End-of-conversion flag, busy clear, result and interrupt gating.
    av(IDX_CONTROL_1, 8'h02, 1'b1);
    av(IDX_IRQ, 8'h14, 1'b1);
    soft_conv(10'h155);
    rd_check(IDX_CONTROL_0, 8'h00);
    rd_check(IDX_RESULT_LOW, 8'h55);
    rd_check(IDX_RESULT_HIGH, 8'h01);
    rd_check(IDX_IRQ, 8'h17);
    check(irq, 1'b1);
    av(IDX_IRQ, 8'h07, 1'b1);
    @(posedge clk);
    check(irq, 1'b0);
    soft_conv(10'h0aa);
    check(irq, 1'b0);
    rd_check(IDX_IRQ, 8'h07);
    // Every compare mode against bounds 100 and 200, edges included.
    av(IDX_LOW_BOUND_LOW_BYTE, 8'h64, 1'b1);
    av(IDX_HIGH_BOUND_LOW_BYTE, 8'hc8, 1'b1);
    av(IDX_HIGH_BOUND_HIGH_BITS, 8'h00, 1'b1);
    for (int m = 0; m < 4; m++) begin
      av(IDX_CONTROL_1, 8'((m << 3) | 2), 1'b1);
      foreach (rs[i]) begin
        av(IDX_IRQ, 8'h1b, 1'b1);
        soft_conv(10'(rs[i]));
        rd_check(IDX_IRQ, {6'h06, bnd(m, rs[i]), 1'b1});
        check(irq, bnd(m, rs[i]));
      end
    end
    // Timer triggers: period, wrong source, delays, duty channel codes.
    av(IDX_IRQ, 8'h03, 1'b1);
    av(IDX_DELAY, 8'h00, 1'b1);
    av(IDX_CONTROL_1, 8'h82, 1'b1);
    pwm_lat(4'h8, 2);
    pwm_lat(4'h7, 300);
    av(IDX_DELAY, 8'h05, 1'b1);
    av(IDX_CONTROL_1, 8'hc2, 1'b1);
    pwm_lat(4'h8, 7);
    av(IDX_DELAY, 8'h02, 1'b1);
    pwm_lat(4'h8, 4);
    av(IDX_DELAY, 8'hff, 1'b1);
    pwm_lat(4'h8, 257);
    av(IDX_DELAY, 8'h00, 1'b1);
    av(IDX_CONTROL_1, 8'ha2, 1'b1);
    for (int c = 0; c < 4; c++) begin
      ch = (c == 3) ? 2 : c;
      av(IDX_CONTROL_2, 8'(c), 1'b1);
      pwm_lat({1'b1, 3'(3'b001 << ((ch + 1) % 3))}, 300);
      pwm_lat({1'b0, 3'(3'b001 << ch)}, 2);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
